// >>> hw/psg_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the protection signalling block. Assumes a 10 MHz core clock.
`ifndef PSG_DEFINES_SVH
`define PSG_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define PSG_A_PIN_CFG 8'h00
`define PSG_A_FUSE_CFG 8'h04
`define PSG_A_OW_CFG 8'h08
`define PSG_A_IRQ_STAT 8'h0C
`define PSG_A_IRQ_MASK 8'h10
`define PSG_A_STATE 8'h14
`define PSG_A_CELL_FLT 8'h18
`define PSG_A_CELL_PF 8'h1C

// ==========================================================
// Pin configuration fields
`define PSG_F_AFN 2:0
`define PSG_F_ADRV 4:3
`define PSG_B_AHSRC 5
`define PSG_B_AGPO 6
`define PSG_B_APU 7
`define PSG_B_APD 8
// Fault pin slices: [1:0] function, 2 high source, 3 level, 4 pullup, 5 pulldown
`define PSG_FP_BASE 9
`define PSG_FP_W 6

// ==========================================================
// Fuse configuration fields
`define PSG_B_PF_SENSE 0
`define PSG_B_BLOW_EN 1
`define PSG_B_USE_PACK 2
`define PSG_F_THR 31:16

// ==========================================================
// Interrupt status bits
`define PSG_IRQ_W 14
`define PSG_B_IR_CFLT 8
`define PSG_B_IR_DFLT 9
`define PSG_B_IR_FUSE 10
`define PSG_B_IR_PERM 11
`define PSG_B_IR_CELL 12
`define PSG_B_IR_OW 13

// ==========================================================
// Reset values and writable bits
`define PSG_RST_PIN_CFG 32'h0000_0010
`define PSG_RST_ZERO 32'h0000_0000
`define PSG_PIN_CFG_WMASK 32'h001F_FFFF
`define PSG_FUSE_CFG_WMASK 32'hFFFF_0007
`define PSG_OW_CFG_WMASK 32'h0000_FFFF

// ==========================================================
// Timing
`define PSG_CLK_HZ 10000000
`define PSG_OW_ON_MS 3
`define PSG_MS_CYC (`PSG_CLK_HZ / 1000)
`define PSG_OW_ON_CYC (`PSG_OW_ON_MS * `PSG_MS_CYC)

`endif

// >>> hw/psg_ow_timer.sv
// Open-wire current source scheduler.
// Assumes one core clock, a millisecond count in cycles, and an interval in ms.
`include "psg_defines.svh"

module psg_ow_timer #(
  parameter int unsigned MS_CYC = `PSG_MS_CYC,
  parameter int unsigned ON_CYC = `PSG_OW_ON_CYC
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_nrst, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [15:0] i_interval_ms, // Period in ms, zero disables
  output logic o_src_en, // Current source on
  output logic o_done // Pulse at end of an on period
);

  psg_pkg::psg_ow_state_e state;
  psg_pkg::psg_ow_state_e next_state;
  logic [31:0] ms_cnt;
  logic [31:0] on_cnt;
  logic [15:0] ivl_cnt;
  wire ms_tick;
  wire ivl_hit;
  wire on_end;

  // ==========================================================
  // Tick and interval decode
  assign ms_tick = (ms_cnt == MS_CYC - 32'd1);
  assign ivl_hit = ms_tick && (i_interval_ms != 16'h0)
    && (({1'b0, ivl_cnt} + 17'h1) >= {1'b0, i_interval_ms});
  assign on_end = (on_cnt == ON_CYC - 32'd1);
  assign o_src_en = (state == psg_pkg::PSG_OW_ON);

  // Next state; the source stays on for one measurement time
  always_comb
  begin
    case (state)
      psg_pkg::PSG_OW_IDLE:
        next_state = ivl_hit ? psg_pkg::PSG_OW_ON : psg_pkg::PSG_OW_IDLE; // RULE_14
      psg_pkg::PSG_OW_ON:
        next_state = on_end ? psg_pkg::PSG_OW_IDLE : psg_pkg::PSG_OW_ON; // RULE_15
      default: next_state = psg_pkg::PSG_OW_IDLE;
    endcase
  end

  // Counters freeze with the clock enable
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state <= psg_pkg::PSG_OW_IDLE;
      ms_cnt <= 32'h0;
      on_cnt <= 32'h0;
      ivl_cnt <= 16'h0;
      o_done <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
      on_cnt <= o_src_en ? on_cnt + 32'h1 : 32'h0; // RULE_15
      if (o_src_en || ivl_hit)
        ivl_cnt <= 16'h0;
      else if (ms_tick)
        ivl_cnt <= ivl_cnt + 16'h1;
      o_done <= o_src_en && on_end;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_ow_off;
    (i_interval_ms == 16'h0) && !o_src_en |=> !o_src_en;
  endproperty
  a_ow_off: assert property (p_ow_off) else $error("source started while disabled"); // RULE_14

  property p_ow_len;
    o_src_en && on_end && i_ce |=> !o_src_en && o_done;
  endproperty
  a_ow_len: assert property (p_ow_len) else $error("on time not ended"); // RULE_15

  property p_ow_hold;
    o_src_en && !on_end |=> o_src_en;
  endproperty
  a_ow_hold: assert property (p_ow_hold) else $error("on time cut short"); // RULE_15

  c_ow_on: cover property ($rose(o_src_en));

endmodule

// >>> hw/psg_pkg.sv
// Types shared by the protection signalling block.
// Assumes nothing beyond a SystemVerilog compiler.
package psg_pkg;

  // ==========================================================
  // Function of the alarm pin
  typedef enum logic [2:0]
  {
    PSG_AF_ALARM = 3'h0,
    PSG_AF_THERM = 3'h1,
    PSG_AF_ADC = 3'h2,
    PSG_AF_GPO = 3'h3,
    PSG_AF_SWL = 3'h4
  } psg_alarm_fn_e;

  // Function of a fault indication pin
  typedef enum logic [1:0]
  {
    PSG_FF_FAULT = 2'h0,
    PSG_FF_THERM = 2'h1,
    PSG_FF_ADC = 2'h2,
    PSG_FF_GPO = 2'h3
  } psg_fault_fn_e;

  // Output stage style
  typedef enum logic [1:0]
  {
    PSG_DRV_AH = 2'h0,
    PSG_DRV_AL = 2'h1,
    PSG_DRV_OD = 2'h2
  } psg_drive_e;

  // Open-wire source scheduler
  typedef enum logic [1:0]
  {
    PSG_OW_IDLE = 2'b01,
    PSG_OW_ON = 2'b10
  } psg_ow_state_e;

endpackage

// >>> hw/psg_top.sv
// Protection signalling: alarm pin, fault pins, fuse pin, open-wire timer.
// Assumes protection logic on the same clock and a simple register port.
//
// Notes on behaviour
// RULE_01 - Alarm pin: alarm, thermistor, ADC, output, link
// RULE_02 - Alarm drive: active high, low, open drain
// RULE_03 - Single wire link forces open drain
// RULE_04 - High level from 1.8 V or user regulator
// RULE_05 - Three alarm signalling styles supported
// RULE_06 - Only masked-in flags raise the alarm
// RULE_07 - Fault pins: fault, thermistor, ADC, output
// RULE_08 - Fault pins mirror charge and discharge faults
// RULE_09 - Host may use fault pins as interrupts
// RULE_10 - Fuse pin idle high impedance and sensed
// RULE_11 - Sensed fuse high raises permanent failure
// RULE_12 - Blow fuse only above voltage threshold
// RULE_13 - Threshold may use pack voltage instead
// RULE_14 - Open-wire source runs at programmable interval
// RULE_15 - Source on one measurement time, 3 ms
// RULE_16 - Collapse flags the cell and one above
// RULE_17 - Output mode: level, weak pullup or pulldown
// RULE_18 - Alarm holds while unmasked flag set
`include "psg_defines.svh"

module psg_top #(
  parameter int NCELL = 16,
  parameter int unsigned MS_CYC = `PSG_MS_CYC,
  parameter int unsigned OW_ON_CYC = `PSG_OW_ON_CYC
) (
  input wire logic i_core_clk, // Core clock, 10 MHz
  input wire logic i_nrst, // Sync reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_we, // Write strobe
  input wire logic i_re, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  input wire logic [7:0] i_alarm_ev, // Alarm event pulses
  input wire logic i_charge_fault, // Fault that blocks the charge switch
  input wire logic i_discharge_fault, // Fault that blocks the discharge switch
  input wire logic [NCELL-1:0] i_cell_low, // Cell below fault level
  input wire logic [NCELL-1:0] i_cell_dead, // Cell below failure level
  input wire logic [15:0] i_stack_mv, // Stack voltage
  input wire logic [15:0] i_pack_mv, // Pack terminal voltage
  input wire logic i_single_wire_host_link_tx_low, // Link wants pin low
  output logic o_single_wire_host_link_rx, // Link pin level
  input wire logic i_alarm_pin_i, // Alarm pin level
  output logic o_alarm_pin_o, // Alarm pin drive value
  output logic o_alarm_pin_oe, // Alarm pin drive enable
  output logic o_alarm_use_user_regulator_one, // High from user regulator
  output logic o_alarm_pu, // Weak pullup
  output logic o_alarm_pd, // Weak pulldown
  output logic [1:0] o_alarm_ana, // {thermistor, ADC} route
  output logic o_charge_fault_out_o, // Charge fault pin value
  output logic o_charge_fault_out_oe, // Charge fault pin enable
  output logic o_charge_fault_out_user_reg, // High from user regulator
  output logic o_charge_fault_out_pu, // Weak pullup
  output logic o_charge_fault_out_pd, // Weak pulldown
  output logic [1:0] o_charge_fault_out_ana, // {thermistor, ADC} route
  output logic o_discharge_fault_out_o, // Discharge fault pin value
  output logic o_discharge_fault_out_oe, // Discharge fault pin enable
  output logic o_discharge_fault_out_user_reg, // High from user regulator
  output logic o_discharge_fault_out_pu, // Weak pullup
  output logic o_discharge_fault_out_pd, // Weak pulldown
  output logic [1:0] o_discharge_fault_out_ana, // {thermistor, ADC} route
  input wire logic i_fuse_pin_i, // Fuse pin level
  output logic o_fuse_pin_o, // Fuse pin drive value
  output logic o_fuse_pin_oe, // Fuse pin drive enable
  output logic o_permanent_failure, // Sticky permanent failure
  output logic o_ow_src_en, // Open-wire current sources on
  output logic [NCELL-1:0] o_cell_fault, // Per-cell open-wire fault
  output logic o_irq // Level interrupt
);

  // ==========================================================
  // Registers and state
  logic [31:0] pin_cfg;
  logic [31:0] fuse_cfg;
  logic [31:0] ow_cfg;
  logic [`PSG_IRQ_W-1:0] irq_stat;
  logic [`PSG_IRQ_W-1:0] irq_mask;
  logic [NCELL-1:0] cell_pf;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_lvl;
  logic perm_fail;
  logic fuse_drv;
  logic [1:0] flt_q;
  logic cell_any_q;
  logic fuse_seen_q;
  logic [1:0] flt_pin_o;
  logic [1:0] flt_pin_oe;
  wire ow_done;

  // ==========================================================
  // Decode
  wire psg_pkg::psg_alarm_fn_e afn = psg_pkg::psg_alarm_fn_e'(pin_cfg[`PSG_F_AFN]);
  wire psg_pkg::psg_drive_e adrv = psg_pkg::psg_drive_e'(pin_cfg[`PSG_F_ADRV]);
  wire wr_pin = i_we && (i_addr == `PSG_A_PIN_CFG);
  wire wr_fuse = i_we && (i_addr == `PSG_A_FUSE_CFG);
  wire wr_ow = i_we && (i_addr == `PSG_A_OW_CFG);
  wire wr_stat = i_we && (i_addr == `PSG_A_IRQ_STAT);
  wire wr_mask = i_we && (i_addr == `PSG_A_IRQ_MASK);
  wire [1:0] flt_in = {i_discharge_fault, i_charge_fault};
  wire alarm_act = |(irq_stat & irq_mask); // RULE_06
  wire fuse_seen = pin_lvl[0] && !fuse_drv; // RULE_10
  wire [15:0] qual_mv = fuse_cfg[`PSG_B_USE_PACK] ? i_pack_mv : i_stack_mv; // RULE_13
  wire volt_ok = qual_mv > fuse_cfg[`PSG_F_THR]; // RULE_12
  wire cell_any = |o_cell_fault;

  // Permanent failure sources: sensed fuse or a dead cell
  wire next_perm_fail = perm_fail || |i_cell_dead
    || (fuse_cfg[`PSG_B_PF_SENSE] && fuse_seen); // RULE_11

  // Events into the sticky status; a set in the clear cycle wins
  wire [`PSG_IRQ_W-1:0] irq_set = {ow_done, cell_any && !cell_any_q,
    !perm_fail && next_perm_fail, fuse_seen && !fuse_seen_q,
    flt_in & ~flt_q, i_alarm_ev};
  wire [`PSG_IRQ_W-1:0] irq_clr = wr_stat ? i_wdata[`PSG_IRQ_W-1:0] : '0;
  wire [`PSG_IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

  // Alarm pin drive {oe, o}; the link always runs open drain
  wire [1:0] alarm_drv =
    (adrv == psg_pkg::PSG_DRV_AH) ? {1'b1, alarm_act} : // RULE_05
    (adrv == psg_pkg::PSG_DRV_AL) ? {1'b1, !alarm_act} : // RULE_05
    {alarm_act, 1'b0}; // RULE_05
  wire alarm_lvl = pin_cfg[`PSG_B_AGPO];
  wire [1:0] gpo_drv = (adrv == psg_pkg::PSG_DRV_AH || adrv == psg_pkg::PSG_DRV_AL) ?
    {1'b1, alarm_lvl} : {!alarm_lvl, 1'b0}; // RULE_02
  wire [1:0] next_alarm =
    (afn == psg_pkg::PSG_AF_ALARM) ? alarm_drv : // RULE_01
    (afn == psg_pkg::PSG_AF_GPO) ? gpo_drv : // RULE_17
    (afn == psg_pkg::PSG_AF_SWL) ? {i_single_wire_host_link_tx_low, 1'b0} : // RULE_03
    2'b00;

  // ==========================================================
  // Pin options from configuration, plus interrupt, fuse, failure and fault pin outputs
  assign o_alarm_use_user_regulator_one = pin_cfg[`PSG_B_AHSRC]; // RULE_04
  assign o_alarm_pu = (afn == psg_pkg::PSG_AF_GPO) && pin_cfg[`PSG_B_APU]; // RULE_17
  assign o_alarm_pd = (afn == psg_pkg::PSG_AF_GPO) && pin_cfg[`PSG_B_APD]; // RULE_17
  assign o_alarm_ana = {afn == psg_pkg::PSG_AF_THERM, afn == psg_pkg::PSG_AF_ADC}; // RULE_01
  assign o_irq = alarm_act; // RULE_18
  assign o_fuse_pin_o = fuse_drv;
  assign o_fuse_pin_oe = fuse_drv; // RULE_10
  assign o_permanent_failure = perm_fail;
  assign o_charge_fault_out_o = flt_pin_o[0];
  assign o_charge_fault_out_oe = flt_pin_oe[0];
  assign o_discharge_fault_out_o = flt_pin_o[1];
  assign o_discharge_fault_out_oe = flt_pin_oe[1];

  // ==========================================================
  // Fault pins, one slice per channel
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_flt
    wire [`PSG_FP_W-1:0] fc = pin_cfg[`PSG_FP_BASE + ch * `PSG_FP_W +: `PSG_FP_W];
    wire psg_pkg::psg_fault_fn_e fn = psg_pkg::psg_fault_fn_e'(fc[1:0]);
    wire [1:0] next_drv =
      (fn == psg_pkg::PSG_FF_FAULT) ? {1'b1, flt_in[ch]} : // RULE_08
      (fn == psg_pkg::PSG_FF_GPO) ? {1'b1, fc[3]} : // RULE_17
      2'b00; // RULE_07
    wire [1:0] ana = {fn == psg_pkg::PSG_FF_THERM, fn == psg_pkg::PSG_FF_ADC}; // RULE_07
    wire pu = (fn == psg_pkg::PSG_FF_GPO) && fc[4];
    wire pd = (fn == psg_pkg::PSG_FF_GPO) && fc[5];
    if (ch == 0)
    begin : g_c
      assign o_charge_fault_out_user_reg = fc[2]; // RULE_04
      assign o_charge_fault_out_ana = ana;
      assign o_charge_fault_out_pu = pu;
      assign o_charge_fault_out_pd = pd;
    end
    else
    begin : g_d
      assign o_discharge_fault_out_user_reg = fc[2]; // RULE_04
      assign o_discharge_fault_out_ana = ana;
      assign o_discharge_fault_out_pu = pu;
      assign o_discharge_fault_out_pd = pd;
    end
    // Registered so the pin never glitches on decode
    always_ff @(posedge i_core_clk)
    begin
      if (!i_nrst)
      begin
        flt_pin_o[ch] <= 1'b0;
        flt_pin_oe[ch] <= 1'b0;
      end
      else if (i_ce)
      begin
        flt_pin_o[ch] <= next_drv[0];
        flt_pin_oe[ch] <= next_drv[1];
      end
    end
  end

  // ==========================================================
  // Pin synchronisers: bit 0 fuse, bit 1 alarm/link
  for (genvar p = 0; p < 2; p++)
  begin : g_sync
    wire raw = (p == 0) ? i_fuse_pin_i : i_alarm_pin_i;
    // A change counts only once the second and third stages agree
    always_ff @(posedge i_core_clk)
    begin
      if (!i_nrst)
      begin
        pin_s1[p] <= (p == 1); // Alarm line idles high on its pull-up
        pin_s2[p] <= (p == 1);
        pin_s3[p] <= (p == 1);
        pin_lvl[p] <= (p == 1);
      end
      else if (i_ce)
      begin
        pin_s1[p] <= raw;
        pin_s2[p] <= pin_s1[p];
        pin_s3[p] <= pin_s2[p];
        if (pin_s2[p] == pin_s3[p])
          pin_lvl[p] <= pin_s3[p];
      end
    end
  end

  // ==========================================================
  // Per-cell collapse flags land on the cell and the one above
  for (genvar c = 0; c < NCELL; c++)
  begin : g_cell
    wire below_low = (c == 0) ? 1'b0 : i_cell_low[(c == 0) ? 0 : c - 1];
    wire below_dead = (c == 0) ? 1'b0 : i_cell_dead[(c == 0) ? 0 : c - 1];
    always_ff @(posedge i_core_clk)
    begin
      if (!i_nrst)
      begin
        o_cell_fault[c] <= 1'b0;
        cell_pf[c] <= 1'b0;
      end
      else if (i_ce)
      begin
        o_cell_fault[c] <= i_cell_low[c] || below_low; // RULE_16
        cell_pf[c] <= cell_pf[c] || i_cell_dead[c] || below_dead; // RULE_16
      end
    end
  end

  // ==========================================================
  // Open-wire scheduler
  psg_ow_timer #(
    .MS_CYC(MS_CYC),
    .ON_CYC(OW_ON_CYC)
  ) u_ow (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_interval_ms(ow_cfg[15:0]), // RULE_14
    .o_src_en(o_ow_src_en),
    .o_done(ow_done)
  );

  // ==========================================================
  // Configuration registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      pin_cfg <= `PSG_RST_PIN_CFG;
      fuse_cfg <= `PSG_RST_ZERO;
      ow_cfg <= `PSG_RST_ZERO;
      irq_mask <= '0;
    end
    else if (i_ce)
    begin
      if (wr_pin)
        pin_cfg <= i_wdata & `PSG_PIN_CFG_WMASK;
      if (wr_fuse)
        fuse_cfg <= i_wdata & `PSG_FUSE_CFG_WMASK;
      if (wr_ow)
        ow_cfg <= i_wdata & `PSG_OW_CFG_WMASK;
      if (wr_mask)
        irq_mask <= i_wdata[`PSG_IRQ_W-1:0]; // RULE_06
    end
  end

  // Status, failure latch, fuse drive and alarm pin
  // Fuse drive latches: once blowing starts, a sagging stack must not stop it
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      irq_stat <= '0;
      perm_fail <= 1'b0;
      fuse_drv <= 1'b0;
      fuse_seen_q <= 1'b0;
      flt_q <= 2'b00;
      cell_any_q <= 1'b0;
      o_alarm_pin_o <= 1'b0;
      o_alarm_pin_oe <= 1'b0;
      o_single_wire_host_link_rx <= 1'b1;
    end
    else if (i_ce)
    begin
      irq_stat <= next_irq_stat; // RULE_18
      perm_fail <= next_perm_fail; // RULE_11
      fuse_drv <= fuse_drv || (fuse_cfg[`PSG_B_BLOW_EN] && perm_fail && volt_ok); // RULE_12
      fuse_seen_q <= fuse_seen;
      flt_q <= flt_in;
      cell_any_q <= cell_any;
      o_alarm_pin_o <= next_alarm[0];
      o_alarm_pin_oe <= next_alarm[1]; // RULE_02
      o_single_wire_host_link_rx <= (afn == psg_pkg::PSG_AF_SWL) ? pin_lvl[1] : 1'b1;
    end
  end

  // ==========================================================
  // Read port: data only in the cycle after the strobe
  wire [31:0] state_word = {24'h0, cell_pf != '0, flt_in, alarm_act, o_ow_src_en,
    fuse_drv, pin_lvl[0], perm_fail};
  wire [31:0] rd_mux =
    (i_addr == `PSG_A_PIN_CFG) ? pin_cfg :
    (i_addr == `PSG_A_FUSE_CFG) ? fuse_cfg :
    (i_addr == `PSG_A_OW_CFG) ? ow_cfg :
    (i_addr == `PSG_A_IRQ_STAT) ? {{(32-`PSG_IRQ_W){1'b0}}, irq_stat} :
    (i_addr == `PSG_A_IRQ_MASK) ? {{(32-`PSG_IRQ_W){1'b0}}, irq_mask} :
    (i_addr == `PSG_A_STATE) ? state_word :
    (i_addr == `PSG_A_CELL_FLT) ? {{(32-NCELL){1'b0}}, o_cell_fault} :
    (i_addr == `PSG_A_CELL_PF) ? {{(32-NCELL){1'b0}}, cell_pf} :
    32'h0;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      o_rdata <= 32'h0;
    else if (i_ce)
      o_rdata <= i_re ? rd_mux : 32'h0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_swl_od;
    i_ce && afn == psg_pkg::PSG_AF_SWL && !wr_pin
      |=> !o_alarm_pin_o && (o_alarm_pin_oe == $past(i_single_wire_host_link_tx_low));
  endproperty
  a_swl_od: assert property (p_swl_od) else $error("link pin not open drain"); // RULE_03

  property p_alarm_ah;
    i_ce && !wr_pin && afn == psg_pkg::PSG_AF_ALARM && adrv == psg_pkg::PSG_DRV_AH
      |=> o_alarm_pin_oe && (o_alarm_pin_o == $past(o_irq));
  endproperty
  a_alarm_ah: assert property (p_alarm_ah) else $error("active high alarm wrong"); // RULE_05

  property p_alarm_od;
    i_ce && !wr_pin && afn == psg_pkg::PSG_AF_ALARM && adrv == psg_pkg::PSG_DRV_OD
      |=> (o_alarm_pin_oe == $past(o_irq)) && !o_alarm_pin_o;
  endproperty
  a_alarm_od: assert property (p_alarm_od) else $error("open drain alarm wrong"); // RULE_05

  property p_mask;
    irq_mask == '0 |-> !o_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("alarm without enabled flag"); // RULE_06

  property p_alarm_hold;
    o_irq && !wr_stat && !wr_mask |=> o_irq;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early"); // RULE_18

  property p_cflt;
    i_ce && !wr_pin && pin_cfg[`PSG_FP_BASE +: 2] == 2'h0 && i_charge_fault
      |=> o_charge_fault_out_o && o_charge_fault_out_oe;
  endproperty
  a_cflt: assert property (p_cflt) else $error("charge fault pin not set"); // RULE_08

  property p_fuse_hiz;
    !fuse_drv |-> !o_fuse_pin_oe;
  endproperty
  a_fuse_hiz: assert property (p_fuse_hiz) else $error("fuse pin driven idle"); // RULE_10

  property p_pf_sense;
    i_ce [*2] ##0 $past(fuse_cfg[`PSG_B_PF_SENSE] && pin_s2[0] && pin_s3[0] && !fuse_drv)
      && !$past(wr_fuse) |=> o_permanent_failure;
  endproperty
  a_pf_sense: assert property (p_pf_sense) else $error("sensed fuse gave no failure"); // RULE_11

  property p_blow_qual;
    $rose(fuse_drv) |-> $past(volt_ok && perm_fail && fuse_cfg[`PSG_B_BLOW_EN]);
  endproperty
  a_blow_qual: assert property (p_blow_qual) else $error("fuse blown unqualified"); // RULE_12

  property p_pack_sel;
    i_ce && !fuse_drv && fuse_cfg[`PSG_B_USE_PACK] && i_pack_mv <= fuse_cfg[`PSG_F_THR]
      |=> !fuse_drv;
  endproperty
  a_pack_sel: assert property (p_pack_sel) else $error("pack threshold ignored"); // RULE_13

  property p_cell;
    i_ce && i_cell_low[0] |=> o_cell_fault[0] && o_cell_fault[1];
  endproperty
  a_cell: assert property (p_cell) else $error("cell above not flagged"); // RULE_16

  c_alarm: cover property ($rose(o_irq));
  c_blow: cover property ($rose(o_fuse_pin_oe));
  c_swl: cover property (afn == psg_pkg::PSG_AF_SWL && o_alarm_pin_oe);
  c_pf: cover property ($rose(o_permanent_failure));

endmodule

// >>> tb/psg_far_model.sv
// Far side of the pins: host line with pull-up and an external protector.
// Assumes the block's pin enables are high while it drives.
module psg_far_model (
  input wire logic i_alarm_o, // Block alarm value
  input wire logic i_alarm_oe, // Block alarm enable
  input wire logic i_fuse_o, // Block fuse value
  input wire logic i_fuse_oe, // Block fuse enable
  input wire logic i_prot_blow, // Protector drives the fuse gate
  output logic o_alarm_line, // Resolved alarm wire
  output logic o_fuse_line // Resolved fuse wire
);
  // ==========================================================
  // Wire resolution
  // Pull-up keeps an undriven open-drain line high, never unknown
  assign o_alarm_line = i_alarm_oe ? i_alarm_o : 1'b1;
  // Gate has a pull-down; both drivers simply wire-or
  assign o_fuse_line = (i_fuse_oe & i_fuse_o) | i_prot_blow;
endmodule

// >>> tb/tb_psg_top.sv
// Self-checking bench for the protection signalling block.
// Assumes shortened ms and on-time counts passed as parameters.
`include "psg_defines.svh"
module tb_psg_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ON = 30;
  logic clk = 0, nrst = 0, we = 0, re = 0, cf = 0, df = 0, blow = 0, tx = 0, ce = 1;
  logic [7:0] a = 0, ev = 0;
  logic [31:0] wd = 0, rd;
  logic [15:0] low = 0, stk = 0, cellf;
  logic al_o, al_oe, al_line, fu_o, fu_oe, fu_line, c_o, d_o, pf, ow, irq;
  int failures = 0, num_checks = 0, cyc = 0, n;
  always #50 clk = ~clk;
  psg_top #(.MS_CYC(10), .OW_ON_CYC(ON)) DUT (.i_core_clk(clk), .i_nrst(nrst), .i_ce(ce),
    .i_addr(a), .i_wdata(wd), .i_we(we), .i_re(re), .o_rdata(rd), .i_alarm_ev(ev),
    .i_charge_fault(cf), .i_discharge_fault(df), .i_cell_low(low), .i_cell_dead(16'h0000),
    .i_stack_mv(stk), .i_pack_mv(16'h0000), .i_single_wire_host_link_tx_low(tx),
    .o_single_wire_host_link_rx(), .i_alarm_pin_i(al_line), .o_alarm_pin_o(al_o),
    .o_alarm_pin_oe(al_oe), .o_alarm_use_user_regulator_one(), .o_alarm_pu(), .o_alarm_pd(),
    .o_alarm_ana(), .o_charge_fault_out_o(c_o), .o_charge_fault_out_oe(),
    .o_charge_fault_out_user_reg(), .o_charge_fault_out_pu(), .o_charge_fault_out_pd(),
    .o_charge_fault_out_ana(), .o_discharge_fault_out_o(d_o), .o_discharge_fault_out_oe(),
    .o_discharge_fault_out_user_reg(), .o_discharge_fault_out_pu(),
    .o_discharge_fault_out_pd(), .o_discharge_fault_out_ana(), .i_fuse_pin_i(fu_line),
    .o_fuse_pin_o(fu_o), .o_fuse_pin_oe(fu_oe), .o_permanent_failure(pf), .o_ow_src_en(ow),
    .o_cell_fault(cellf), .o_irq(irq));
  psg_far_model far (.i_alarm_o(al_o), .i_alarm_oe(al_oe), .i_fuse_o(fu_o),
    .i_fuse_oe(fu_oe), .i_prot_blow(blow), .o_alarm_line(al_line), .o_fuse_line(fu_line));
  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Register write: one strobe cycle, then released
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    a <= ad;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rdc(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    re <= 1'b1;
    a <= ad;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rd, e);
  endtask
  task w(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task t_alarm;
    rdc(`PSG_A_PIN_CFG, 32'h0000_0010);
    rdc(8'h40, 32'h0000_0000);
    wr(`PSG_A_IRQ_MASK, 32'h0000_0001);
    @(posedge clk);
    ev <= 8'h01;
    @(posedge clk);
    ev <= 8'h00;
    w(2);
    chk({irq, al_line}, 2'h2);
    wr(`PSG_A_PIN_CFG, 32'h0000_0000);
    w(2);
    chk({al_oe, al_o}, 2'h3);
    wr(`PSG_A_PIN_CFG, 32'h0000_0008);
    w(2);
    chk({al_oe, al_o}, 2'h2);
    // Output use with pulls, thermistor on charge pin, output on discharge pin
    wr(`PSG_A_PIN_CFG, 32'h000F_83E3);
    w(2);
    chk(DUT.o_alarm_use_user_regulator_one, 1'b1);
    chk({DUT.o_alarm_pu, DUT.o_alarm_pd, al_oe, al_o}, 4'hF);
    chk({DUT.o_charge_fault_out_ana, DUT.o_charge_fault_out_oe, DUT.o_discharge_fault_out_user_reg,
      DUT.o_discharge_fault_out_pu, DUT.o_discharge_fault_out_pd, d_o}, 7'h4D);
    // Link use with a push-pull setting must still only pull low
    wr(`PSG_A_PIN_CFG, 32'h0000_0004);
    @(posedge clk);
    tx <= 1'b1;
    w(2);
    chk({al_oe, al_o}, 2'h2);
    tx <= 1'b0;
    wr(`PSG_A_PIN_CFG, 32'h0000_0010);
    wr(`PSG_A_IRQ_MASK, 32'h0000_0000);
    w(2);
    chk({irq, al_line}, 2'h1);
    wr(`PSG_A_IRQ_MASK, 32'h0000_0001);
    w(2);
    chk(irq, 1'b1);
    wr(`PSG_A_IRQ_STAT, 32'h0000_0001);
    w(2);
    chk({irq, al_line}, 2'h1);
  endtask
  task t_fault;
    @(posedge clk);
    cf <= 1'b1;
    low <= 16'h0008;
    w(2);
    chk(c_o, 1'b1);
    chk(cellf, 32'h0000_0018);
    // Clock enable low must freeze the fault pins
    @(posedge clk);
    ce <= 1'b0;
    df <= 1'b1;
    cf <= 1'b0;
    low <= 16'h0000;
    w(2);
    chk({c_o, d_o}, 2'h2);
    @(posedge clk);
    ce <= 1'b1;
    w(2);
    chk({c_o, d_o}, 2'h1);
  endtask
  // Open-wire source: find the on period and time it
  task t_ow;
    wr(`PSG_A_OW_CFG, 32'h0000_0001);
    n = 0;
    while (!ow && n < 100)
    begin
      w(1);
      n++;
    end
    n = 0;
    while (ow && n < 100)
    begin
      w(1);
      n++;
    end
    chk(n, ON);
    rdc(`PSG_A_IRQ_STAT, 32'h0000_3300);
    wr(`PSG_A_OW_CFG, 32'h0000_0000);
  endtask
  // Fuse last: failure and drive stay until reset
  task t_fuse;
    wr(`PSG_A_FUSE_CFG, 32'h0064_0003);
    @(posedge clk);
    stk <= 16'h0032;
    blow <= 1'b1;
    w(8);
    chk({pf, fu_oe}, 2'h2);
    chk(fu_oe, 1'b0);
    // Pack qualification: stack is high but pack stays at zero
    wr(`PSG_A_FUSE_CFG, 32'h0064_0007);
    @(posedge clk);
    blow <= 1'b0;
    stk <= 16'h00C8;
    w(3);
    chk({fu_oe, fu_o}, 2'h0);
    wr(`PSG_A_FUSE_CFG, 32'h0064_0003);
    w(3);
    chk({fu_oe, fu_o}, 2'h3);
  endtask
  task test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Cut a hang short well after the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      test_done();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_alarm();
    t_fault();
    t_ow();
    t_fuse();
    test_done();
  end
endmodule
